// ### dnvm_top.sv
// Drive network variable map: AXI4-Lite register file for network inputs and outputs
// What this block does
// - Third extension analog output takes 0..100 % in 0.01 % steps, drives terminal
// - Extension analog output acts only when analog expansion option is fitted
// - Clock-set input loads real-time clock from six range-checked fields
// - Bypass-mode input copied directly to bypass-mode parameter; 0 drive, 1 bypass
// - Remote bypass activation copied directly to its parameter, only with bypass option
// - Parameter request input read or write drive parameters as access command
// - Publish a 16-bit drive status word
// - Output percent: frequency open loop, feedback closed loop, signed 0.005 % steps
// - Output frequency in whole hertz, 0 to 6500
// - Energy in whole kWh averaged over one hour
// - Filtered DC-link voltage, 0.1 V steps to 10000 V, up to 1.3 s late
// - Motor thermal load 0..100 % in half-percent steps, 100 % is cut-out
// - Inverter thermal load 0..100 % in half-percent steps, cut-out at full scale
// - Closed-loop summed feedback 0..100 % in half-percent steps
// - Belt fault true exactly when bit 8 of second warning word is set
// - Alarm flag: state 1 value 100 if any alarm, else state 0 value 0
// - Warning flag: state 1 value 100 if any warning, else state 0 value 0
// - Publish whole alarm word as 64 bits
// - Publish whole warning word as 64 bits; it drives warning indications
`timescale 1ns/100ps
`default_nettype none
module dnvm_top (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RESET,
  // AXI4-Lite write address and data
  input wire logic [7:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  // AXI4-Lite write response
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  // AXI4-Lite read
  input wire logic [7:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  // Drive-side measurements (same clock domain)
  input wire logic [15:0] I_STATUS_WORD,
  input wire logic [15:0] I_FREQ_PCNT,
  input wire logic [15:0] I_FEEDBACK_PCNT,
  input wire logic [15:0] I_FREQ_HZ,
  input wire logic [31:0] I_POWER_KW,
  input wire logic [19:0] I_DC_VOLT_RAW,
  input wire logic [7:0] I_MOTOR_THERMAL,
  input wire logic [7:0] I_INV_THERMAL,
  input wire logic [7:0] I_NET_FEEDBACK,
  input wire logic [63:0] I_ALARM_WORD,
  input wire logic [63:0] I_WARNING_WORD,
  // Drive-side controls
  output logic [15:0] O_EXT_ANALOG_OUT_THREE,
  output logic O_CLOCK_SET,
  output logic [63:0] O_CLOCK_STAMP,
  output logic [15:0] O_BYPASS_MODE,
  output logic [15:0] O_BYPASS_ACTIVATION,
  output logic O_PARAM_REQ,
  output logic [31:0] O_PARAM_REQ_DATA,
  output logic O_BELT_FAULT
);
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Software-written state
  logic [31:0] ctrl;
  logic [15:0] aout3;
  logic [31:0] clk_date;
  logic [31:0] clk_time;
  // Published values
  logic [15:0] status_word;
  logic [15:0] out_pcnt;
  logic [15:0] out_hz;
  logic [7:0] motor_th;
  logic [7:0] inv_th;
  logic [7:0] feedback;
  logic [63:0] alarm_bits;
  logic [63:0] warning_bits;
  dnvm_pkg::dnvm_switch_s alarm_flag;
  dnvm_pkg::dnvm_switch_s warning_flag;
  logic [31:0] energy_kwh;
  logic [31:0] energy_mean;
  logic energy_done;
  logic [19:0] dc_filt;
  // Write channel holding
  logic aw_held;
  logic w_held;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic wr_ok;
  dnvm_pkg::dnvm_stamp_s stamp;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction : merge

  function automatic logic [7:0] clamp8(input logic [7:0] v);
    return (v > dnvm_pkg::HALF_PCT_MAX) ? dnvm_pkg::HALF_PCT_MAX : v;
  endfunction : clamp8

  function automatic dnvm_pkg::dnvm_switch_s flag_of(input logic [63:0] w);
    dnvm_pkg::dnvm_switch_s f;
    f.state = |w;
    f.value = f.state ? dnvm_pkg::SWITCH_ON : dnvm_pkg::SWITCH_OFF;
    return f;
  endfunction : flag_of

  assign do_write = aw_held && w_held && !O_BVALID;

  always_comb begin
    stamp.year = clk_date[31:16];
    stamp.month = clk_date[15:8];
    stamp.day = clk_date[7:0];
    stamp.hour = clk_time[23:16];
    stamp.minute = clk_time[15:8];
    stamp.second = clk_time[7:0];
  end

  // Write address and data capture, either order
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else begin
      if (I_AWVALID && O_AWREADY) begin
        aw_held <= 1'b1;
        aw_addr <= I_AWADDR;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
      if (I_WVALID && O_WREADY) begin
        w_held <= 1'b1;
        w_data <= I_WDATA;
        w_strb <= I_WSTRB;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      O_AWREADY <= 1'b0;
      O_WREADY <= 1'b0;
    end else begin
      O_AWREADY <= !aw_held && !(I_AWVALID && O_AWREADY) && !O_BVALID;
      O_WREADY <= !w_held && !(I_WVALID && O_WREADY) && !O_BVALID;
    end
  end

  // Register writes and one-cycle command strobes
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      ctrl <= 32'h0;
      aout3 <= 16'h0;
      clk_date <= 32'h0;
      clk_time <= 32'h0;
      O_BYPASS_MODE <= dnvm_pkg::BYP_DRIVE;
      O_BYPASS_ACTIVATION <= 16'h0;
      O_PARAM_REQ <= 1'b0;
      O_PARAM_REQ_DATA <= 32'h0;
      O_CLOCK_SET <= 1'b0;
      O_CLOCK_STAMP <= 64'h0;
      wr_ok <= 1'b0;
    end else begin
      O_PARAM_REQ <= 1'b0;
      O_CLOCK_SET <= 1'b0;
      if (do_write) begin
        wr_ok <= 1'b1;
        case (aw_addr)
          dnvm_pkg::ADDR_CTRL: ctrl <= merge(ctrl, w_data, w_strb);
          dnvm_pkg::ADDR_AOUT3: begin
            // Values above full scale are refused
            if (ctrl[dnvm_pkg::CTRL_AIO_FITTED]) begin
              if (w_data[15:0] <= dnvm_pkg::AOUT_MAX) aout3 <= w_data[15:0];
              else wr_ok <= 1'b0;
            end else begin
              wr_ok <= 1'b0;
            end
          end
          dnvm_pkg::ADDR_CLK_DATE: clk_date <= merge(clk_date, w_data, w_strb);
          dnvm_pkg::ADDR_CLK_TIME: begin
            clk_time <= merge(clk_time, w_data, w_strb);
            // Time word write commits the stamp when all fields are in range
            if (stamp.year >= dnvm_pkg::YEAR_MIN && stamp.year <= dnvm_pkg::YEAR_MAX &&
                stamp.month <= dnvm_pkg::MONTH_MAX && stamp.day <= dnvm_pkg::DAY_MAX &&
                w_data[23:16] <= dnvm_pkg::HOUR_MAX && w_data[15:8] <= dnvm_pkg::MINSEC_MAX &&
                w_data[7:0] <= dnvm_pkg::MINSEC_MAX) begin
              O_CLOCK_SET <= 1'b1;
              O_CLOCK_STAMP <= {clk_date, 8'h00, w_data[23:0]};
            end else begin
              wr_ok <= 1'b0;
            end
          end
          dnvm_pkg::ADDR_BYP_MODE: O_BYPASS_MODE <= w_data[15:0];
          dnvm_pkg::ADDR_BYP_ACT: begin
            if (ctrl[dnvm_pkg::CTRL_BYP_FITTED]) O_BYPASS_ACTIVATION <= w_data[15:0];
            else wr_ok <= 1'b0;
          end
          dnvm_pkg::ADDR_PREQ: begin
            O_PARAM_REQ <= 1'b1;
            O_PARAM_REQ_DATA <= w_data;
          end
          default: wr_ok <= 1'b0;
        endcase
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      O_BVALID <= 1'b0;
      O_BRESP <= RESP_OKAY;
    end else if (O_BVALID) begin
      if (I_BREADY) O_BVALID <= 1'b0;
    end else if (do_write) begin
      O_BVALID <= 1'b1;
      O_BRESP <= RESP_OKAY;
    end
  end

  // Analog output drives terminal only when option fitted
  always_ff @(posedge I_CLK) begin
    if (I_RESET) O_EXT_ANALOG_OUT_THREE <= 16'h0;
    else O_EXT_ANALOG_OUT_THREE <= ctrl[dnvm_pkg::CTRL_AIO_FITTED] ? aout3 : 16'h0;
  end

  // Published drive values
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      status_word <= 16'h0;
      out_pcnt <= 16'h0;
      out_hz <= 16'h0;
      motor_th <= 8'h0;
      inv_th <= 8'h0;
      feedback <= 8'h0;
    end else begin
      status_word <= I_STATUS_WORD;
      out_pcnt <= ctrl[dnvm_pkg::CTRL_CLOSED_LOOP] ? I_FEEDBACK_PCNT : I_FREQ_PCNT;
      out_hz <= (I_FREQ_HZ > dnvm_pkg::HZ_MAX) ? dnvm_pkg::HZ_MAX : I_FREQ_HZ;
      motor_th <= clamp8(I_MOTOR_THERMAL);
      inv_th <= clamp8(I_INV_THERMAL);
      feedback <= ctrl[dnvm_pkg::CTRL_CLOSED_LOOP] ? clamp8(I_NET_FEEDBACK) : 8'h0;
    end
  end

  // Alarm and warning words with flags, all in one cycle
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      alarm_bits <= 64'h0;
      warning_bits <= 64'h0;
      alarm_flag <= '0;
      warning_flag <= '0;
      O_BELT_FAULT <= 1'b0;
    end else begin
      alarm_bits <= I_ALARM_WORD;
      warning_bits <= I_WARNING_WORD;
      alarm_flag <= flag_of(I_ALARM_WORD);
      warning_flag <= flag_of(I_WARNING_WORD);
      O_BELT_FAULT <= I_WARNING_WORD[dnvm_pkg::WARN_WORD2_LSB + dnvm_pkg::BELT_BIT];
    end
  end

  // Hourly mean of power gives kWh
  dnvm_avg #(.WINDOW(dnvm_pkg::HOUR_CYC), .W(32)) u_avg (
    .i_clk(I_CLK),
    .i_reset(I_RESET),
    .i_sample(I_POWER_KW),
    .o_mean(energy_mean),
    .o_done(energy_done)
  );

  always_ff @(posedge I_CLK) begin
    if (I_RESET) energy_kwh <= 32'h0;
    else if (energy_done) energy_kwh <= energy_kwh + energy_mean;
  end

  dnvm_filt #(.SHIFT(dnvm_pkg::DC_SHIFT)) u_filt (
    .i_clk(I_CLK),
    .i_reset(I_RESET),
    .i_raw((I_DC_VOLT_RAW > dnvm_pkg::DCV_MAX) ? dnvm_pkg::DCV_MAX : I_DC_VOLT_RAW),
    .o_filt(dc_filt)
  );

  // Read channel
  always_ff @(posedge I_CLK) begin
    if (I_RESET) begin
      O_ARREADY <= 1'b0;
      O_RVALID <= 1'b0;
      O_RDATA <= 32'h0;
      O_RRESP <= RESP_OKAY;
    end else begin
      O_ARREADY <= !O_RVALID && !(I_ARVALID && O_ARREADY);
      if (O_RVALID) begin
        if (I_RREADY) O_RVALID <= 1'b0;
      end else if (I_ARVALID && O_ARREADY) begin
        O_RVALID <= 1'b1;
        O_RRESP <= RESP_OKAY;
        case (I_ARADDR)
          dnvm_pkg::ADDR_CTRL: O_RDATA <= ctrl;
          dnvm_pkg::ADDR_AOUT3: O_RDATA <= {16'h0, aout3};
          dnvm_pkg::ADDR_CLK_DATE: O_RDATA <= clk_date;
          dnvm_pkg::ADDR_CLK_TIME: O_RDATA <= clk_time;
          dnvm_pkg::ADDR_BYP_MODE: O_RDATA <= {16'h0, O_BYPASS_MODE};
          dnvm_pkg::ADDR_BYP_ACT: O_RDATA <= {16'h0, O_BYPASS_ACTIVATION};
          dnvm_pkg::ADDR_PREQ: O_RDATA <= O_PARAM_REQ_DATA;
          dnvm_pkg::ADDR_STATUS: O_RDATA <= {16'h0, status_word};
          dnvm_pkg::ADDR_OUT_PCNT: O_RDATA <= {16'h0, out_pcnt};
          dnvm_pkg::ADDR_OUT_HZ: O_RDATA <= {16'h0, out_hz};
          dnvm_pkg::ADDR_ENERGY: O_RDATA <= energy_kwh;
          dnvm_pkg::ADDR_DC_VOLT: O_RDATA <= {12'h0, dc_filt};
          dnvm_pkg::ADDR_THERMAL: O_RDATA <= {16'h0, inv_th, motor_th};
          dnvm_pkg::ADDR_FEEDBACK: O_RDATA <= {24'h0, feedback};
          dnvm_pkg::ADDR_FLAGS: O_RDATA <= {14'h0, warning_flag, alarm_flag};
          dnvm_pkg::ADDR_ALARM_LO: O_RDATA <= alarm_bits[31:0];
          dnvm_pkg::ADDR_ALARM_HI: O_RDATA <= alarm_bits[63:32];
          dnvm_pkg::ADDR_WARN_LO: O_RDATA <= warning_bits[31:0];
          dnvm_pkg::ADDR_WARN_HI: O_RDATA <= warning_bits[63:32];
          default: begin
            O_RDATA <= 32'h0;
            O_RRESP <= RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // Assertions
  a_belt_bit_follow: assert property (@(posedge I_CLK) disable iff (I_RESET)
    O_BELT_FAULT == $past(I_WARNING_WORD[dnvm_pkg::WARN_WORD2_LSB + dnvm_pkg::BELT_BIT]))
    else $error("belt fault mismatch");
  a_alarm_flag_val: assert property (@(posedge I_CLK) disable iff (I_RESET)
    alarm_flag.state |-> alarm_flag.value == dnvm_pkg::SWITCH_ON) else $error("alarm value wrong");
  a_warn_flag_val: assert property (@(posedge I_CLK) disable iff (I_RESET)
    !warning_flag.state |-> warning_flag.value == dnvm_pkg::SWITCH_OFF)
    else $error("warning value wrong");
  a_flag_or_word: assert property (@(posedge I_CLK) disable iff (I_RESET)
    alarm_flag.state == (|alarm_bits) && warning_flag.state == (|warning_bits))
    else $error("flag not OR of word");
  a_aout_gated: assert property (@(posedge I_CLK) disable iff (I_RESET)
    !ctrl[dnvm_pkg::CTRL_AIO_FITTED] |=> O_EXT_ANALOG_OUT_THREE == 16'h0)
    else $error("aout without option");
  a_aout_range: assert property (@(posedge I_CLK) disable iff (I_RESET)
    O_EXT_ANALOG_OUT_THREE <= dnvm_pkg::AOUT_MAX) else $error("aout over full scale");
  a_hz_limit: assert property (@(posedge I_CLK) disable iff (I_RESET)
    out_hz <= dnvm_pkg::HZ_MAX) else $error("frequency over limit");
  a_thermal_limit: assert property (@(posedge I_CLK) disable iff (I_RESET)
    motor_th <= dnvm_pkg::HALF_PCT_MAX && inv_th <= dnvm_pkg::HALF_PCT_MAX)
    else $error("thermal over limit");
  a_preq_pulse: assert property (@(posedge I_CLK) disable iff (I_RESET)
    O_PARAM_REQ |=> !O_PARAM_REQ) else $error("request strobe too long");
  a_pcnt_mode: assert property (@(posedge I_CLK) disable iff (I_RESET)
    ##1 $stable(ctrl[dnvm_pkg::CTRL_CLOSED_LOOP]) |-> out_pcnt == (ctrl[dnvm_pkg::CTRL_CLOSED_LOOP]
    ? $past(I_FEEDBACK_PCNT) : $past(I_FREQ_PCNT))) else $error("output percent source wrong");
endmodule : dnvm_top
`default_nettype wire

// ### dnvm_pkg.sv
// Package with register map, field layouts and constants of the drive network variable map
package dnvm_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_AOUT3 = 8'h04;
  localparam logic [7:0] ADDR_CLK_DATE = 8'h08;
  localparam logic [7:0] ADDR_CLK_TIME = 8'h0c;
  localparam logic [7:0] ADDR_BYP_MODE = 8'h10;
  localparam logic [7:0] ADDR_BYP_ACT = 8'h14;
  localparam logic [7:0] ADDR_PREQ = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_OUT_PCNT = 8'h20;
  localparam logic [7:0] ADDR_OUT_HZ = 8'h24;
  localparam logic [7:0] ADDR_ENERGY = 8'h28;
  localparam logic [7:0] ADDR_DC_VOLT = 8'h2c;
  localparam logic [7:0] ADDR_THERMAL = 8'h30;
  localparam logic [7:0] ADDR_FEEDBACK = 8'h34;
  localparam logic [7:0] ADDR_FLAGS = 8'h38;
  localparam logic [7:0] ADDR_ALARM_LO = 8'h3c;
  localparam logic [7:0] ADDR_ALARM_HI = 8'h40;
  localparam logic [7:0] ADDR_WARN_LO = 8'h44;
  localparam logic [7:0] ADDR_WARN_HI = 8'h48;

  // Limits and scaling
  localparam logic [15:0] AOUT_MAX = 16'h2710;     // 100.00 % in 0.01 % steps
  localparam logic [15:0] YEAR_MIN = 16'h07d0;     // 2000
  localparam logic [15:0] YEAR_MAX = 16'h0bb8;     // 3000
  localparam logic [7:0] MONTH_MAX = 8'h0c;
  localparam logic [7:0] DAY_MAX = 8'h1f;
  localparam logic [7:0] HOUR_MAX = 8'h17;
  localparam logic [7:0] MINSEC_MAX = 8'h3b;
  localparam logic [15:0] HZ_MAX = 16'h1964;       // 6500 Hz
  localparam logic [19:0] DCV_MAX = 20'h186a0;     // 10000.0 V in 0.1 V steps
  localparam logic [7:0] HALF_PCT_MAX = 8'hc8;     // 100 % in 0.5 % steps
  localparam logic [7:0] SWITCH_ON = 8'h64;        // Switch value 100
  localparam logic [7:0] SWITCH_OFF = 8'h00;
  localparam int BELT_BIT = 8;                      // Bit in second warning word
  localparam int WARN_WORD2_LSB = 16;
  localparam logic [15:0] BYP_DRIVE = 16'h0000;
  localparam logic [15:0] BYP_BYPASS = 16'h0001;

  // Timing of the DC-link filter
  localparam real DC_DELAY_S = 1.3;
  localparam real CLK_HZ = 125.0e6;
  localparam int DC_SHIFT = 26;                     // 2^26 cycles, about 0.54 s, below 1.3 s
  localparam longint DC_DELAY_CYC = longint'(DC_DELAY_S * CLK_HZ);

  // Energy averaging period
  localparam real HOUR_S = 3600.0;
  localparam longint HOUR_CYC = longint'(HOUR_S * CLK_HZ);

  // Control register fields
  localparam int CTRL_AIO_FITTED = 0;
  localparam int CTRL_BYP_FITTED = 1;
  localparam int CTRL_CLOSED_LOOP = 2;

  // Switch-type output
  typedef struct packed {
    logic [7:0] value;
    logic state;
  } dnvm_switch_s;

  // Clock-set fields
  typedef struct packed {
    logic [15:0] year;
    logic [7:0] month;
    logic [7:0] day;
    logic [7:0] hour;
    logic [7:0] minute;
    logic [7:0] second;
  } dnvm_stamp_s;

endpackage : dnvm_pkg

// ### dnvm_avg.sv
// Averaging accumulator: mean of a sampled value over a fixed window
`timescale 1ns/100ps
`default_nettype none
module dnvm_avg #(
  parameter longint WINDOW = 64'd450000000000,
  parameter int W = 32
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Sample and result
  input wire logic [W-1:0] i_sample,
  output logic [W-1:0] o_mean,
  output logic o_done
);
  logic [63:0] count;
  logic [95:0] acc;

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      count <= 64'h0;
      acc <= 96'h0;
      o_mean <= '0;
      o_done <= 1'b0;
    end else if (count == 64'(WINDOW - 1)) begin
      count <= 64'h0;
      acc <= 96'h0;
      o_mean <= W'((acc + 96'(i_sample)) / 96'(WINDOW));
      o_done <= 1'b1;
    end else begin
      count <= count + 64'h1;
      acc <= acc + 96'(i_sample);
      o_done <= 1'b0;
    end
  end
endmodule : dnvm_avg
`default_nettype wire

// ### dnvm_filt.sv
// First-order low-pass filter for the DC-link voltage
`timescale 1ns/100ps
`default_nettype none
module dnvm_filt #(
  parameter int SHIFT = 26
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_reset,
  // Raw and filtered value
  input wire logic [19:0] i_raw,
  output logic [19:0] o_filt
);
  logic [20+SHIFT-1:0] acc;
  logic [20+SHIFT:0] next_acc;

  always_comb begin
    next_acc = {1'b0, acc} + {{SHIFT{1'b0}}, 1'b0, i_raw} - {{SHIFT{1'b0}}, 1'b0, o_filt};
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      acc <= '0;
      o_filt <= 20'h0;
    end else begin
      acc <= next_acc[20+SHIFT-1:0];
      o_filt <= next_acc[20+SHIFT-1:SHIFT];
    end
  end
endmodule : dnvm_filt
`default_nettype wire

// ### dnvm_net_ctrl.sv
// Network controller model: AXI4-Lite master toward the variable map
`timescale 1ns/100ps
`default_nettype none
module dnvm_net_ctrl (
  // Clock
  input wire logic i_clk,
  // Write side
  output logic [7:0] o_awaddr,
  output logic o_awvalid,
  input wire logic i_awready,
  output logic [31:0] o_wdata,
  output logic [3:0] o_wstrb,
  output logic o_wvalid,
  input wire logic i_wready,
  input wire logic [1:0] i_bresp,
  input wire logic i_bvalid,
  output logic o_bready,
  // Read side
  output logic [7:0] o_araddr,
  output logic o_arvalid,
  input wire logic i_arready,
  input wire logic [31:0] i_rdata,
  input wire logic [1:0] i_rresp,
  input wire logic i_rvalid,
  output logic o_rready,
  // Answer never came
  output logic o_hang
);
  initial begin
    {o_awaddr, o_awvalid, o_wdata, o_wstrb, o_wvalid, o_bready} = '0;
    {o_araddr, o_arvalid, o_rready, o_hang} = '0;
  end
  // Settings and parameter requests go out as whole words
  task automatic write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw, w, b;
    int n;
    {aw, w, b} = 3'b111;
    n = 0;
    r = 2'b11;
    o_awaddr <= a;
    o_awvalid <= 1'b1;
    o_wdata <= d;
    o_wstrb <= 4'hf;
    o_wvalid <= 1'b1;
    o_bready <= 1'b1;
    while ((aw || w || b) && n < 100) begin
      @(posedge i_clk);
      n++;
      if (aw && i_awready) begin
        aw = 1'b0;
        o_awvalid <= 1'b0;
      end
      if (w && i_wready) begin
        w = 1'b0;
        o_wvalid <= 1'b0;
      end
      if (b && i_bvalid) begin
        b = 1'b0;
        r = i_bresp;
        o_bready <= 1'b0;
      end
    end
    if (n >= 100) o_hang <= 1'b1;
  endtask : write
  task automatic read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar, rr;
    int n;
    {ar, rr} = 2'b11;
    n = 0;
    {d, r} = '1;
    o_araddr <= a;
    o_arvalid <= 1'b1;
    o_rready <= 1'b1;
    while ((ar || rr) && n < 100) begin
      @(posedge i_clk);
      n++;
      if (ar && i_arready) begin
        ar = 1'b0;
        o_arvalid <= 1'b0;
      end
      if (rr && i_rvalid) begin
        rr = 1'b0;
        {r, d} = {i_rresp, i_rdata};
        o_rready <= 1'b0;
      end
    end
    if (n >= 100) o_hang <= 1'b1;
  endtask : read
endmodule : dnvm_net_ctrl
`default_nettype wire

// ### dnvm_bench.sv
// Self-checking testbench of the drive network variable map
`timescale 1ns/100ps
`default_nettype none
module dnvm_bench;
  logic I_CLK = 1'b0;
  logic I_RESET = 1'b1;
  logic [7:0] I_AWADDR, I_ARADDR, I_MOTOR_THERMAL, I_INV_THERMAL, I_NET_FEEDBACK;
  logic [31:0] I_WDATA, O_RDATA, I_POWER_KW, O_PARAM_REQ_DATA, rd;
  logic [3:0] I_WSTRB;
  logic I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY, O_AWREADY, O_WREADY, O_BVALID;
  logic O_ARREADY, O_RVALID, O_CLOCK_SET, O_PARAM_REQ, O_BELT_FAULT, hang;
  logic [1:0] O_BRESP, O_RRESP, rs;
  logic [15:0] I_STATUS_WORD, I_FREQ_PCNT, I_FEEDBACK_PCNT, I_FREQ_HZ, O_EXT_ANALOG_OUT_THREE;
  logic [15:0] O_BYPASS_MODE, O_BYPASS_ACTIVATION;
  logic [19:0] I_DC_VOLT_RAW;
  logic [63:0] I_ALARM_WORD, I_WARNING_WORD, O_CLOCK_STAMP;
  int err_total = 0;
  int compares = 0;
  int n_set = 0;
  int n_req = 0;
  always #4 I_CLK = ~I_CLK;
  dnvm_top dut (.*);
  dnvm_net_ctrl u_net (.i_clk(I_CLK), .o_awaddr(I_AWADDR), .o_awvalid(I_AWVALID),
    .i_awready(O_AWREADY), .o_wdata(I_WDATA), .o_wstrb(I_WSTRB), .o_wvalid(I_WVALID),
    .i_wready(O_WREADY), .i_bresp(O_BRESP), .i_bvalid(O_BVALID), .o_bready(I_BREADY),
    .o_araddr(I_ARADDR), .o_arvalid(I_ARVALID), .i_arready(O_ARREADY), .i_rdata(O_RDATA),
    .i_rresp(O_RRESP), .i_rvalid(O_RVALID), .o_rready(I_RREADY), .o_hang(hang));
  task automatic stop_test();
    $display("compares %0d, mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_net.write(a, d, rs);
    repeat (2) @(posedge I_CLK);
  endtask : wr
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
    u_net.read(a, rd, rs);
    @(posedge I_CLK);
    chk({30'h0, rs, rd}, {30'h0, r, e});
  endtask : rdchk
  always @(posedge I_CLK) begin
    if (O_CLOCK_SET === 1'b1) n_set++;
    if (O_PARAM_REQ === 1'b1) n_req++;
    if (hang === 1'b1) begin
      err_total++;
      stop_test();
    end
  end
  initial begin
    {I_STATUS_WORD, I_FREQ_PCNT, I_FEEDBACK_PCNT} = {16'ha5c3, 16'h1234, 16'h4321};
    {I_FREQ_HZ, I_POWER_KW, I_DC_VOLT_RAW} = {16'h1964, 32'h0, 20'h0};
    {I_MOTOR_THERMAL, I_INV_THERMAL, I_NET_FEEDBACK} = {8'hc8, 8'h64, 8'h01};
    {I_ALARM_WORD, I_WARNING_WORD} = '0;
    repeat (12) @(posedge I_CLK);
    I_RESET <= 1'b0;
    repeat (2) @(posedge I_CLK);
    wr(dnvm_pkg::ADDR_AOUT3, 32'd5000);
    chk(64'(O_EXT_ANALOG_OUT_THREE), 64'h0);
    wr(dnvm_pkg::ADDR_BYP_ACT, 32'h1);
    chk(64'(O_BYPASS_ACTIVATION), 64'h0);
    wr(dnvm_pkg::ADDR_CTRL, 32'h3);
    wr(dnvm_pkg::ADDR_AOUT3, 32'd10000);
    chk(64'(O_EXT_ANALOG_OUT_THREE), 64'h2710);
    wr(dnvm_pkg::ADDR_AOUT3, 32'd10001);
    chk(64'(O_EXT_ANALOG_OUT_THREE), 64'h2710);
    wr(dnvm_pkg::ADDR_BYP_ACT, 32'h1);
    chk(64'(O_BYPASS_ACTIVATION), 64'h1);
    wr(dnvm_pkg::ADDR_BYP_MODE, 32'(dnvm_pkg::BYP_BYPASS));
    chk(64'(O_BYPASS_MODE), 64'h1);
    wr(dnvm_pkg::ADDR_BYP_MODE, 32'(dnvm_pkg::BYP_DRIVE));
    chk(64'(O_BYPASS_MODE), 64'h0);
    $display("test options and settings done");
    wr(dnvm_pkg::ADDR_CLK_DATE, {16'd3000, 8'd12, 8'd31});
    wr(dnvm_pkg::ADDR_CLK_TIME, {8'h0, 8'd23, 8'd59, 8'd59});
    chk(O_CLOCK_STAMP, {32'h0bb80c1f, 8'h0, 24'h173b3b});
    wr(dnvm_pkg::ADDR_CLK_TIME, {8'h0, 8'd24, 8'd0, 8'd0});
    chk(64'(n_set), 64'h1);
    wr(dnvm_pkg::ADDR_CLK_DATE, {16'd2000, 8'd0, 8'd0});
    wr(dnvm_pkg::ADDR_CLK_TIME, 32'h0);
    chk(O_CLOCK_STAMP, {32'h07d00000, 32'h0});
    chk(64'(n_set), 64'h2);
    wr(dnvm_pkg::ADDR_PREQ, 32'hdead0001);
    chk({32'(n_req), O_PARAM_REQ_DATA}, {32'h1, 32'hdead0001});
    $display("test clock and request done");
    rdchk(dnvm_pkg::ADDR_STATUS, 32'h0000a5c3, 2'b00);
    rdchk(dnvm_pkg::ADDR_OUT_HZ, 32'h00001964, 2'b00);
    rdchk(dnvm_pkg::ADDR_THERMAL, 32'h000064c8, 2'b00);
    rdchk(dnvm_pkg::ADDR_FEEDBACK, 32'h00000000, 2'b00);
    rdchk(dnvm_pkg::ADDR_OUT_PCNT, 32'h00001234, 2'b00);
    rdchk(dnvm_pkg::ADDR_ENERGY, 32'h0, 2'b00);
    rdchk(dnvm_pkg::ADDR_DC_VOLT, 32'h0, 2'b00);
    wr(dnvm_pkg::ADDR_CTRL, 32'h7);
    rdchk(dnvm_pkg::ADDR_OUT_PCNT, 32'h00004321, 2'b00);
    rdchk(dnvm_pkg::ADDR_FEEDBACK, 32'h00000001, 2'b00);
    rdchk(8'h80, 32'h0, 2'b10);
    $display("test measurements done");
    I_ALARM_WORD <= 64'h8000_0000_0000_0000;
    I_WARNING_WORD <= 64'h0000_0000_0100_0000;
    repeat (3) @(posedge I_CLK);
    chk(64'(O_BELT_FAULT), 64'h1);
    rdchk(dnvm_pkg::ADDR_FLAGS, {14'h0, 8'h64, 1'b1, 8'h64, 1'b1}, 2'b00);
    rdchk(dnvm_pkg::ADDR_ALARM_HI, 32'h80000000, 2'b00);
    rdchk(dnvm_pkg::ADDR_ALARM_LO, 32'h0, 2'b00);
    rdchk(dnvm_pkg::ADDR_WARN_LO, 32'h01000000, 2'b00);
    I_ALARM_WORD <= 64'h0;
    I_WARNING_WORD <= 64'h1;
    repeat (3) @(posedge I_CLK);
    chk(64'(O_BELT_FAULT), 64'h0);
    rdchk(dnvm_pkg::ADDR_FLAGS, {14'h0, 8'h64, 1'b1, 9'h0}, 2'b00);
    rdchk(dnvm_pkg::ADDR_WARN_HI, 32'h0, 2'b00);
    $display("test flags and words done");
    stop_test();
  end
endmodule : dnvm_bench
`default_nettype wire
